// ---- clock_gen_defines.svh ----
// field positions, codes, reset values and timing counts of the clock generator
`ifndef CLOCK_GEN_DEFINES_SVH
`define CLOCK_GEN_DEFINES_SVH

// clock mode register layout and reset value
`define CM_RESET_VALUE 8'h00
`define CM_DIV_MSB 7
`define CM_DIV_LSB 6
`define CM_SEL_MSB 5
`define CM_SEL_LSB 4
`define CM_MAIN_STOP_BIT 2
`define CM_HS_STOP_BIT 1
`define CM_LS_STOP_BIT 0

// clock selection field codes
`define SEL_LS 2'h0
`define SEL_HS 2'h1
`define SEL_MAIN 2'h2

// division field codes
`define DIV_BY1 2'h3
`define DIV_BY2 2'h2
`define DIV_BY4 2'h1
`define DIV_BY8 2'h0

// oscillation method codes of option byte one
`define METHOD_UNUSED 2'h0
`define METHOD_XIN 2'h1
`define METHOD_SUB_OSCILLATOR_INPUT 2'h2
`define METHOD_EXT 2'h3

// stabilisation preload values
`define TIMER1_STAB_VALUE 8'h01
`define PRESCALER12_STAB_VALUE 8'hFF

// on-chip oscillator periods and derived cycle counts
`define CLOCK_PERIOD_NS 10
`define LS_PERIOD_NS 1000
`define HS_PERIOD_NS 20
`define LS_DIV_CYCLES ((`LS_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define HS_DIV_CYCLES ((`HS_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// low-speed ticks without a main edge that count as a stop
`define DET_LS_TICKS 4'h8

`endif

// ---- clock_gen_pkg.sv ----
// types shared by the clock generator modules
package clock_gen_pkg;

  typedef enum logic [1:0] {
    RUN,
    WAIT_HALT,
    STOP_HALT,
    STOP_STAB
  } halt_state_type;

  typedef struct packed {
    logic [1:0] div;
    logic [1:0] sel;
    logic reserved;
    logic main_stop;
    logic hs_stop;
    logic ls_stop;
  } clock_mode_type;

  typedef struct packed {
    logic ls_lock;
    logic [1:0] method;
  } option_type;

  typedef struct packed {
    logic reset_en;
    logic active;
  } detector_write_type;

  typedef struct packed {
    logic reset_en;
    logic active;
    logic status;
  } detector_state_type;

endpackage

// ---- tick_divider.sv ----
// one-cycle tick every ratio cycles while the oscillator runs
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int unsigned RATIO = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  output logic tick
);
  logic [7:0] count_r;
  logic last_w;

  assign last_w = (count_r == 8'(RATIO - 1));

  // count restarts whenever the oscillator is stopped
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_r <= 8'h00;
    end else if (!run || last_w) begin
      count_r <= 8'h00;
    end else begin
      count_r <= count_r + 8'h01;
    end
  end

  assign tick = run && last_w;
endmodule // tick_divider
`default_nettype wire

// ---- osc_stop_monitor.sv ----
// counts low-speed ticks between main edges and flags a missing oscillation
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_defines.svh"
module osc_stop_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic ls_tick,
  input wire logic main_edge,
  output logic stop_seen
);
  logic [3:0] gap_r;
  logic hit_w;

  assign hit_w = enable && ls_tick && (gap_r == (`DET_LS_TICKS - 4'h1));

  // any main edge restarts the gap; saturates so the flag pulses once
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gap_r <= 4'h0;
    end else if (!enable || main_edge) begin
      gap_r <= 4'h0;
    end else if (ls_tick && gap_r != `DET_LS_TICKS) begin
      gap_r <= gap_r + 4'h1;
    end
  end

  assign stop_seen = hit_w;
endmodule // osc_stop_monitor
`default_nettype wire

// ---- clock_gen_lowpower_osc_monitor.sv ----
// clock generator with stop/wait modes and main oscillation stop detector
// Function
// - stop instruction halts cpu clock high and stops oscillators, low-speed lock aside.
// - stop with stabilisation bit 0 loads timer 1 with 01, prescaler with FF.
// - stop with stabilisation bit 1 leaves timer 1 and prescaler untouched.
// - external interrupt in stop restarts oscillators, clock held high until timer 1 underflow.
// - reset leaves stop without any stabilisation wait.
// - wait instruction halts cpu clock high, oscillators keep their state.
// - wait ends at once on reset or accepted interrupt.
// - low-speed lock ignores writes of 1 to its stop bit, runs in stop.
// - after reset root is low-speed oscillator, cpu clock divided by 8.
// - unused oscillation pins block writing selection code 10.
// - active detector with low-speed running sets status when main stops.
// - reset enable plus detected stop raises an internal reset.
// - detector reset keeps active and status; external reset clears both.
// - writing 0 to active also clears status.
// - power-on, low-voltage, watchdog and stop-function resets clear status.
// - re-enabling detector reset with retained bits resets again at once.
// - watchdog underflow or stop-function reset may set status while active.
// - detector watches main input, resonator or external clock alike.
// - division field gives root divided by 1, 2, 4 or 8.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_defines.svh"
module clock_gen_lowpower_osc_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic main_oscillator_input,
  input wire logic sub_oscillator_input,
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic interrupt_accepted,
  input wire logic external_interrupt_accepted,
  input wire logic stab_set_bit,
  input wire logic timer1_underflow,
  input wire clock_gen_pkg::option_type options,
  input wire logic cm_wr_en,
  input wire clock_gen_pkg::clock_mode_type cm_wr_data,
  input wire logic det_wr_en,
  input wire clock_gen_pkg::detector_write_type det_wr_data,
  input wire logic power_on_reset,
  input wire logic low_voltage_reset,
  input wire logic watchdog_reset,
  input wire logic watchdog_underflow,
  input wire logic stop_function_reset,
  input wire logic stop_function_select,
  output logic cpu_clock,
  output clock_gen_pkg::halt_state_type halt_state,
  output clock_gen_pkg::clock_mode_type clock_mode_register,
  output logic main_osc_enable,
  output logic hs_osc_enable,
  output logic ls_osc_enable,
  output logic timer1_load,
  output logic [7:0] timer1_load_value,
  output logic [7:0] prescaler12_load_value,
  output clock_gen_pkg::detector_state_type detector,
  output logic osc_stop_reset
);
  import clock_gen_pkg::*;

  halt_state_type state_r, state_nxt;
  clock_mode_type cm_r, cm_nxt;
  logic phi_r, phi_nxt;
  logic [2:0] div_count_r;
  logic [1:0] pin_w;
  logic [1:0] edge_w;
  logic [1:0] s1_r, s2_r, s3_r, stable_r;
  logic load_r;
  logic active_r, status_r, reset_en_r, det_reset_r;
  logic sync_reset_w, stop_halt_w, halted_w;
  logic main_run_w, hs_run_w, ls_run_w;
  logic ls_tick_w, hs_tick_w, main_tick_w, sub_tick_w, ext_tick_w, root_tick_w;
  logic stop_seen_w, det_set_w, det_clear_w, fire_w, sel_change_w;
  logic [2:0] div_limit_w;

  // limit of the phase counter for a division code
  function automatic logic [2:0] div_limit(input logic [1:0] code);
    case (code)
      `DIV_BY1: div_limit = 3'h0;
      `DIV_BY2: div_limit = 3'h1;
      `DIV_BY4: div_limit = 3'h3;
      default: div_limit = 3'h7;
    endcase
  endfunction

  // oscillator pins come from other clocks: three flops, edge once stage two and three agree
  assign pin_w = {sub_oscillator_input, main_oscillator_input};
  for (genvar i = 0; i < 2; i++) begin : g_pin_sync
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        stable_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= pin_w[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          stable_r[i] <= s3_r[i];
        end
      end
    end
    assign edge_w[i] = (s2_r[i] == s3_r[i]) && (s3_r[i] != stable_r[i]);
  end

  // oscillators stop in stop mode, low-speed under lock aside; wait keeps whatever ran before
  assign sync_reset_w = power_on_reset || low_voltage_reset || watchdog_reset
                        || stop_function_reset || det_reset_r;
  // oscillators wait for the parked high phase, or a stop taken while low would freeze it low
  assign stop_halt_w = (state_r == STOP_HALT) && phi_r;
  assign halted_w = (state_r != RUN);
  assign main_run_w = !cm_r.main_stop && !stop_halt_w;
  assign hs_run_w = !cm_r.hs_stop && !stop_halt_w;
  assign ls_run_w = !cm_r.ls_stop && (!stop_halt_w || options.ls_lock);

  tick_divider #(.RATIO(`LS_DIV_CYCLES)) u_ls_osc (
    .clock(clock),
    .reset(reset),
    .run(ls_run_w),
    .tick(ls_tick_w)
  );

  tick_divider #(.RATIO(`HS_DIV_CYCLES)) u_hs_osc (
    .clock(clock),
    .reset(reset),
    .run(hs_run_w),
    .tick(hs_tick_w)
  );

  // root clock source; the external clock arrives on the main input
  assign main_tick_w = edge_w[0] && main_run_w;
  assign sub_tick_w = edge_w[1] && main_run_w;
  assign ext_tick_w = (options.method == `METHOD_XIN && main_tick_w)
                      || (options.method == `METHOD_SUB_OSCILLATOR_INPUT && sub_tick_w)
                      || (options.method == `METHOD_EXT && main_tick_w);
  assign root_tick_w = (cm_r.sel == `SEL_LS) ? ls_tick_w :
                       (cm_r.sel == `SEL_HS) ? hs_tick_w :
                       (cm_r.sel == `SEL_MAIN) ? ext_tick_w : 1'b0;

  // detector sees raw main input edges whatever the method
  osc_stop_monitor u_monitor (
    .clock(clock),
    .reset(reset),
    .enable(active_r && ls_run_w),
    .ls_tick(ls_tick_w),
    .main_edge(edge_w[0]),
    .stop_seen(stop_seen_w)
  );

  // halt sequencing; reset paths skip the stabilisation wait
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RUN: begin
        if (stop_instruction) begin
          state_nxt = STOP_HALT;
        end else if (wait_instruction) begin
          state_nxt = WAIT_HALT;
        end
      end
      WAIT_HALT: begin
        if (interrupt_accepted) begin
          state_nxt = RUN;
        end
      end
      STOP_HALT: begin
        if (external_interrupt_accepted) begin
          state_nxt = STOP_STAB;
        end
      end
      STOP_STAB: begin
        if (timer1_underflow) begin
          state_nxt = RUN;
        end
      end
      default: state_nxt = RUN;
    endcase
  end

  // clock mode write with lock and unused-pin filters
  assign sel_change_w = cm_wr_en && (cm_nxt.sel != cm_r.sel);
  always_comb begin
    cm_nxt = cm_r;
    if (cm_wr_en) begin
      cm_nxt = cm_wr_data;
      cm_nxt.reserved = 1'b0;
      if (options.ls_lock) begin
        cm_nxt.ls_stop = 1'b0;
      end
      if (options.method == `METHOD_UNUSED && cm_wr_data.sel == `SEL_MAIN) begin
        cm_nxt.sel = cm_r.sel;
      end
    end
  end

  // cpu clock moves only on root ticks, so no phase is ever short; halts park it high
  assign div_limit_w = div_limit(cm_r.div);
  assign phi_nxt = (halted_w && phi_r) ? 1'b1 : !phi_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= RUN;
      cm_r <= `CM_RESET_VALUE;
      phi_r <= 1'b1;
      div_count_r <= 3'h0;
      load_r <= 1'b0;
    end else if (sync_reset_w) begin
      state_r <= RUN;
      cm_r <= `CM_RESET_VALUE;
      phi_r <= 1'b1;
      div_count_r <= 3'h0;
      load_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cm_r <= cm_nxt;
      load_r <= (state_r == RUN) && stop_instruction && !stab_set_bit;
      if (sel_change_w) begin
        div_count_r <= 3'h0;
      end else if (root_tick_w) begin
        if (div_count_r >= div_limit_w) begin
          div_count_r <= 3'h0;
          phi_r <= phi_nxt;
        end else begin
          div_count_r <= div_count_r + 3'h1;
        end
      end
    end
  end

  // detector flags; a status set in the same cycle beats any status clear
  assign det_set_w = active_r && (stop_seen_w || watchdog_underflow
                     || (stop_function_reset && stop_function_select));
  assign det_clear_w = (det_wr_en && !det_wr_data.active)
                       || power_on_reset || low_voltage_reset || watchdog_reset
                       || stop_function_reset;
  assign fire_w = reset_en_r && active_r && status_r && !det_reset_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      active_r <= 1'b0;
      status_r <= 1'b0;
      reset_en_r <= 1'b0;
      det_reset_r <= 1'b0;
    end else begin
      det_reset_r <= fire_w;
      if (det_set_w) begin
        status_r <= 1'b1;
      end else if (det_clear_w) begin
        status_r <= 1'b0;
      end
      if (power_on_reset) begin
        active_r <= 1'b0;
      end else if (det_wr_en) begin
        active_r <= det_wr_data.active;
      end
      // detector reset keeps active and status but drops the enable
      if (det_reset_r || sync_reset_w) begin
        reset_en_r <= 1'b0;
      end else if (det_wr_en) begin
        reset_en_r <= det_wr_data.reset_en;
      end
    end
  end

  // outputs
  assign cpu_clock = phi_r;
  assign halt_state = state_r;
  assign clock_mode_register = cm_r;
  assign main_osc_enable = main_run_w;
  assign hs_osc_enable = hs_run_w;
  assign ls_osc_enable = ls_run_w;
  assign timer1_load = load_r;
  assign timer1_load_value = `TIMER1_STAB_VALUE;
  assign prescaler12_load_value = `PRESCALER12_STAB_VALUE;
  assign detector = '{reset_en: reset_en_r, active: active_r, status: status_r};
  assign osc_stop_reset = det_reset_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence stop_entry;
    (state_r == RUN) && stop_instruction && !sync_reset_w;
  endsequence

  sequence stop_wake;
    (state_r == STOP_HALT) && external_interrupt_accepted && !sync_reset_w;
  endsequence

  stop_load_a: assert property (stop_entry and !stab_set_bit |=> load_r ##1 !load_r)
    else $error("stop with bit 0 did not preload timer");
  stop_keep_a: assert property (stop_entry and stab_set_bit |=> !load_r)
    else $error("stop with bit 1 touched timer");
  stop_halt_a: assert property (stop_entry ##1 phi_r
                                |-> stop_halt_w && !hs_run_w && !main_run_w)
    else $error("stop did not halt oscillators");
  stab_hold_a: assert property (stop_wake ##1 (phi_r && !timer1_underflow && !sync_reset_w)
                                |=> phi_r && state_r == STOP_STAB)
    else $error("cpu clock released before underflow");
  wait_wake_a: assert property ((state_r == WAIT_HALT) && interrupt_accepted
                                |=> state_r == RUN)
    else $error("wait not left at once");
  ls_lock_a: assert property (options.ls_lock && cm_wr_en && !sync_reset_w
                              |=> !cm_r.ls_stop)
    else $error("locked low-speed stop bit written");
  sel_block_a: assert property (options.method == `METHOD_UNUSED && cm_wr_en && !sync_reset_w
                                && cm_wr_data.sel == `SEL_MAIN
                                |=> cm_r.sel == $past(cm_r.sel))
    else $error("selection 10 written with pins unused");
  det_retain_a: assert property (det_reset_r && !det_clear_w |=> active_r && status_r)
    else $error("detector reset lost retained bits");
  det_clear_a: assert property (det_wr_en && !det_wr_data.active && !det_set_w
                                |=> !status_r)
    else $error("status not cleared by active 0");
  redo_reset_a: assert property (fire_w |=> det_reset_r ##1 !det_reset_r)
    else $error("detector reset not raised");
endmodule // clock_gen_lowpower_osc_monitor
`default_nettype wire

// ---- osc_model.sv ----
// behavioural resonator and sub oscillator on the far side of the clock pins
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
  parameter int MAIN_HALF_NS = 35,
  parameter int SUB_HALF_NS = 700
) (
  input wire logic enable,
  input wire logic broken,
  output logic main_pin,
  output logic sub_pin
);
  // main resonator swings only while enabled; a broken crystal freezes the line
  initial begin
    main_pin = 1'b0;
    forever begin
      #(MAIN_HALF_NS);
      if (enable && !broken) main_pin = ~main_pin;
    end
  end

  // sub oscillator runs free, it is never switched off here
  initial begin
    sub_pin = 1'b0;
    forever begin
      #(SUB_HALF_NS);
      sub_pin = ~sub_pin;
    end
  end
endmodule // osc_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench of the clock generator with stop, wait and detector
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_defines.svh"
module tb_top;
  import clock_gen_pkg::*;
  logic clock, reset, main_pin, sub_pin, stop_i, wait_i, irq, ext_irq, stab, t1_uf;
  logic cm_we, det_we, wd_uf, sf_sel, broken, cpu_clock, timer1_load, osc_stop_reset;
  logic main_en, hs_en, ls_en, hit, hi;
  logic [3:0] sres;
  logic [7:0] t1_val, ps_val;
  option_type options;
  clock_mode_type cm_data, cm, d;
  detector_write_type det_data;
  detector_state_type detector;
  halt_state_type halt_state;
  int fail_count, checked, cycles, cnt;

  clock_gen_lowpower_osc_monitor i_clock_gen_lowpower_osc_monitor (
    .clock(clock), .reset(reset), .main_oscillator_input(main_pin),
    .sub_oscillator_input(sub_pin), .stop_instruction(stop_i), .wait_instruction(wait_i),
    .interrupt_accepted(irq), .external_interrupt_accepted(ext_irq), .stab_set_bit(stab),
    .timer1_underflow(t1_uf), .options(options), .cm_wr_en(cm_we), .cm_wr_data(cm_data),
    .det_wr_en(det_we), .det_wr_data(det_data), .power_on_reset(sres[0]),
    .low_voltage_reset(sres[1]), .watchdog_reset(sres[2]), .watchdog_underflow(wd_uf),
    .stop_function_reset(sres[3]), .stop_function_select(sf_sel), .cpu_clock(cpu_clock),
    .halt_state(halt_state), .clock_mode_register(cm), .main_osc_enable(main_en),
    .hs_osc_enable(hs_en), .ls_osc_enable(ls_en), .timer1_load(timer1_load),
    .timer1_load_value(t1_val), .prescaler12_load_value(ps_val), .detector(detector),
    .osc_stop_reset(osc_stop_reset));

  osc_model i_osc_model (.enable(main_en), .broken(broken), .main_pin(main_pin),
    .sub_pin(sub_pin));

  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // hang guard, the whole run needs far fewer cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 12000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // expected register after a write: lock and unused pins refuse some values
  function automatic clock_mode_type exp_cm(clock_mode_type old, clock_mode_type w,
                                            option_type o);
    clock_mode_type r;
    r = w;
    r.reserved = 1'b0;
    if (o.ls_lock) r.ls_stop = 1'b0;
    if (o.method == `METHOD_UNUSED && w.sel == `SEL_MAIN) r.sel = old.sel;
    return r;
  endfunction

  // every clock mode register write is compared against the expected stored value
  task automatic cm_write(input clock_mode_type w);
    clock_mode_type e;
    e = exp_cm(cm, w, options);
    cm_data = w;
    cm_we = 1'b1;
    tick(1);
    cm_we = 1'b0;
    chk("clock_mode_register", e, cm);
    tick(1);
  endtask

  task automatic det_write(input detector_write_type w);
    det_data = w;
    det_we = 1'b1;
    tick(1);
    det_we = 1'b0;
    tick(1);
  endtask

  // drive only the chosen strobe, so back-to-back pulses never touch one signal twice
  task automatic drive(input int which, input logic v);
    case (which)
      0: stop_i = v;
      1: wait_i = v;
      2: irq = v;
      3: ext_irq = v;
      4: t1_uf = v;
      default: wd_uf = v;
    endcase
  endtask

  // pulse one of the single-cycle strobes chosen by index
  task automatic strobe(input int which);
    drive(which, 1'b1);
    tick(1);
    drive(which, 1'b0);
  endtask

  // watch for the internal reset request within a bounded window
  task automatic wait_rst(input int limit, output logic seen);
    seen = 1'b0;
    repeat (limit) begin
      if (osc_stop_reset === 1'b1) seen = 1'b1;
      if (!seen) tick(1);
    end
  endtask

  task automatic high_check(input string what);
    hi = 1'b1;
    repeat (20) begin
      tick(1);
      hi = hi & (cpu_clock === 1'b1);
    end
    chk(what, 8'h01, {7'h00, hi});
  endtask

  // count cpu clock changes over n cycles
  task automatic count_toggles(input int n);
    cnt = 0;
    repeat (n) begin
      hi = cpu_clock;
      tick(1);
      if (cpu_clock !== hi) cnt++;
    end
  endtask

  initial begin
    {reset, stop_i, wait_i, irq, ext_irq, stab, t1_uf, cm_we, det_we, wd_uf} = 10'h200;
    {sf_sel, broken, sres, cm_data, det_data} = 16'h0000;
    options = 3'h1;
    void'($urandom(70));
    repeat (10) @(posedge clock);
    #1 reset = 1'b0;
    tick(1);
    chk("cpu_clock", 8'h01, {7'h00, cpu_clock});
    chk("reset cm", `CM_RESET_VALUE, cm);
    chk("detector", 8'h00, {5'h00, detector});
    // random writes keep sel and never stop the low-speed source in use
    for (int i = 0; i < 40; i++) begin
      d = clock_mode_type'(8'($urandom));
      d.sel = cm.sel;
      d.ls_stop = 1'b0;
      options = option_type'(3'($urandom));
      cm_write(d);
    end
    // stop bits and selection go in separate writes
    d = cm;
    {d.main_stop, d.hs_stop, d.ls_stop} = 3'h0;
    cm_write(d);
    options = {1'b0, `METHOD_UNUSED};
    d.sel = `SEL_MAIN;
    cm_write(d);
    options = {1'b0, `METHOD_XIN};
    cm_write(d);
    d.sel = `SEL_HS;
    cm_write(d);
    options = {1'b1, `METHOD_XIN};
    d.ls_stop = 1'b1;
    cm_write(d);
    chk("ls enable", 8'h01, {7'h00, ls_en});
    // toggle count over 200 hs ticks for each division code
    for (int k = 0; k < 4; k++) begin
      d.div = k[1:0];
      cm_write(d);
      tick(20);
      count_toggles(400);
      chk("toggles", 8'(25 << k), (cnt >= (25 << k) - 2 && cnt <= (25 << k) + 2) ?
          8'(25 << k) : 8'(cnt));
    end
    // sub pin as root: one phase per pin change, a change every 70 cycles at ratio 1
    options = {1'b1, `METHOD_SUB_OSCILLATOR_INPUT};
    d.sel = `SEL_MAIN;
    cm_write(d);
    count_toggles(700);
    chk("sub toggles", 8'h0A, (cnt >= 9 && cnt <= 11) ? 8'h0A : 8'(cnt));
    d.sel = `SEL_HS;
    cm_write(d);
    // wait: clock held high, oscillators untouched, wake at once
    strobe(1);
    chk("wait state", {6'h00, WAIT_HALT}, {6'h00, halt_state});
    chk("wait enables", 8'h07, {5'h00, main_en, hs_en, ls_en});
    // a low phase still finishes on the next root tick before the clock parks
    tick(2);
    high_check("wait clock");
    strobe(2);
    chk("wait wake", {6'h00, RUN}, {6'h00, halt_state});
    // stop with hardware preload, then external wake and stabilisation
    strobe(0);
    chk("stop state", {6'h00, STOP_HALT}, {6'h00, halt_state});
    chk("t1 load", 8'h01, {7'h00, timer1_load});
    chk("t1 value", `TIMER1_STAB_VALUE, t1_val);
    chk("ps value", `PRESCALER12_STAB_VALUE, ps_val);
    // oscillators stop once the cpu clock has reached its high phase
    tick(10);
    chk("stop enables", 8'h01, {5'h00, main_en, hs_en, ls_en});
    strobe(3);
    chk("stab state", {6'h00, STOP_STAB}, {6'h00, halt_state});
    high_check("stab clock");
    strobe(4);
    chk("stop wake", {6'h00, RUN}, {6'h00, halt_state});
    // software preload: no hardware load pulse
    stab = 1'b1;
    strobe(0);
    chk("no t1 load", 8'h00, {7'h00, timer1_load});
    tick(5);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(1);
    chk("reset wake", {6'h00, RUN}, {6'h00, halt_state});
    // detector: clear, arm, then break the crystal
    det_write(2'b00);
    det_write(2'b11);
    tick(300);
    chk("armed", 8'h06, {5'h00, detector});
    broken = 1'b1;
    wait_rst(1500, hit);
    chk("stop reset", 8'h01, {7'h00, hit});
    tick(2);
    chk("kept bits", 8'h03, {5'h00, detector});
    chk("cm after", `CM_RESET_VALUE, cm);
    det_data = 2'b11;
    det_we = 1'b1;
    tick(1);
    det_we = 1'b0;
    wait_rst(4, hit);
    chk("redo reset", 8'h01, {7'h00, hit});
    broken = 1'b0;
    tick(2);
    det_write(2'b00);
    chk("clear status", 8'h00, {5'h00, detector});
    // power-on, low-voltage, watchdog and stop-function resets each clear status, only power-on clears active
    for (int j = 0; j < 4; j++) begin
      det_write(2'b00);
      det_write(2'b01);
      strobe(5);
      tick(1);
      chk("wdt status", 8'h03, {5'h00, detector});
      sres[j] = 1'b1;
      tick(1);
      sres[j] = 1'b0;
      tick(1);
      chk("sync reset", (j == 0) ? 8'h00 : 8'h02, {5'h00, detector});
    end
    strobe(5);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(1);
    chk("ext reset", 8'h00, {5'h00, detector});
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
